//--- adq_top.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`include "adq_params.svh"

// Overview of operation
// - Trigger with mode 1011 and converter on sets start bit, starting conversion.
// - Every special event trigger pulses the timer clear output.
// - Converter off: trigger starts nothing, but still clears the timer.
// - With TRIG_FIRST set the trigger comes from the first compare unit, else the second.
// - Result is unsigned 8-bit; code one begins at reference over 256.
// - Larger control layout: clock 7:6, channel 5:3, start 2, on 0.
// - Smallest control layout: clock 7:6, channel 4:3, start 2, flag 1, on 0.
// - Port configuration field: three bits, two on smallest, resets to zero.
// - Done flag and its enable sit in bit 6 of flag/enable registers.
// - Smallest variants: done enable bit 6 of core register, global enable 7.
// - Unimplemented register bits read as zero.
// - Finished conversion clears start bit, loads result, sets done flag.
// - Clearing start mid-conversion aborts, keeps result, waits two clocks.
// - Clock select 11 picks RC clock, waits one instruction, runs in sleep.
// - Any reset restores registers, turns converter off, aborts conversion.

module adq_top
   import adq_pkg::*;
#(
   parameter bit SMALL      = 1'b0,
   parameter bit TRIG_FIRST = 1'b0
) (
   input  wire logic     clk,
   input  wire logic     rst_n,
   input  wire adq_bus_t bus,
   output logic [7:0]    rdata,
   input  wire adq_cmp_t cmp1,
   input  wire adq_cmp_t cmp2,
   input  wire logic     comp_pin,
   input  wire logic     rc_clk_pin,
   input  wire logic     sleep,
   output logic          irq,
   output logic          timer_clear,
   output adq_ana_t      ana
);

   localparam logic [7:0] CTRL_OFF   = SMALL ? `ADQ_S_CTRL : `ADQ_L_CTRL;
   localparam logic [7:0] RESULT_OFF = SMALL ? `ADQ_S_RESULT : `ADQ_L_RESULT;
   localparam logic [7:0] CFG_OFF    = SMALL ? `ADQ_S_CFG : `ADQ_L_CFG;
   localparam logic [2:0] INSTR_LAST = 3'(`ADQ_INSTR_CYC - 1);

   if (`ADQ_INSTR_CYC < 1 || `ADQ_INSTR_CYC > 8) begin : g_chk
      $error("adq_top: instruction wait does not fit its counter");
   end

   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   function automatic logic [4:0] tad_limit(input logic [1:0] sel);
      case (sel)
         2'h0:    tad_limit = `ADQ_DIV_2T;
         2'h1:    tad_limit = `ADQ_DIV_8T;
         default: tad_limit = `ADQ_DIV_32T;
      endcase
   endfunction

   adq_state_t st_ff;
   adq_state_t nxt_st;

   adq_cmp_t   sel_cmp;
   logic       trig_hit;
   logic       rc_mode;
   logic       tad_tick;
   logic       wr_ctrl;
   logic       sar_start;
   logic       sar_abort;
   logic       sar_busy;
   logic       sar_done;
   logic [7:0] sar_trial;
   logic [7:0] sar_result;
   logic       flag_set;
   logic       flag_clr;

   // ----------------------------------------
   // Trigger source and conversion clock
   // ----------------------------------------
   assign sel_cmp  = TRIG_FIRST ? cmp1 : cmp2;
   assign trig_hit = sel_cmp.event_p && (sel_cmp.mode == `ADQ_SPECIAL_TRIG);
   assign rc_mode  = (st_ff.ctrl.clk_sel == `ADQ_CS_RC);
   // RC clock edges come from the filtered pin, never the raw one
   assign tad_tick = rc_mode ? (st_ff.stable[1] & ~st_ff.rc_prev)
                             : (st_ff.div_cnt == tad_limit(st_ff.ctrl.clk_sel));
   assign wr_ctrl  = bus.wr && hit(bus.addr, CTRL_OFF);

   adq_sar #(
      .WIDTH (8)
   ) u_sar (
      .clk    (clk),
      .rst_n  (rst_n),
      .start  (sar_start),
      .abort  (sar_abort),
      .tick   (tad_tick),
      .comp   (st_ff.stable[0]),
      .busy   (sar_busy),
      .done   (sar_done),
      .trial  (sar_trial),
      .result (sar_result)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      nxt_st    = st_ff;
      sar_start = 1'b0;
      sar_abort = 1'b0;
      flag_set  = 1'b0;
      flag_clr  = 1'b0;

      // Three-stage filter: a change counts once stages two and three agree
      nxt_st.sync1 = {rc_clk_pin, comp_pin};
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.sync3 = st_ff.sync2;
      for (int i = 0; i < 2; i++) begin
         if (st_ff.sync2[i] == st_ff.sync3[i]) begin
            nxt_st.stable[i] = st_ff.sync3[i];
         end
      end
      nxt_st.rc_prev = st_ff.stable[1];

      if (st_ff.fsm == ST_ACQ || st_ff.fsm == ST_RCWAIT || tad_tick) begin
         nxt_st.div_cnt = 5'h00;
      end else begin
         nxt_st.div_cnt = st_ff.div_cnt + 5'h01;
      end

      // Timer clear does not depend on the converter being on
      nxt_st.tclr = trig_hit;

      // Software writes
      if (wr_ctrl) begin
         nxt_st.ctrl.clk_sel = bus.wdata[7:6];
         nxt_st.ctrl.chan    = SMALL ? {1'b0, bus.wdata[4:3]} : bus.wdata[5:3];
         nxt_st.ctrl.on      = bus.wdata[`ADQ_B_ON];
         nxt_st.ctrl.go      = bus.wdata[`ADQ_B_GO] & bus.wdata[`ADQ_B_ON];
         flag_clr            = SMALL && bus.wdata[`ADQ_B_FLAG_S];
      end
      if (bus.wr && hit(bus.addr, RESULT_OFF)) begin
         nxt_st.result = bus.wdata;
      end
      if (bus.wr && hit(bus.addr, CFG_OFF)) begin
         nxt_st.cfg = SMALL ? {1'b0, bus.wdata[1:0]} : bus.wdata[2:0];
      end
      if (!SMALL && bus.wr && hit(bus.addr, `ADQ_L_FLAGS)) begin
         flag_clr = bus.wdata[`ADQ_B_DONE];
      end
      if (!SMALL && bus.wr && hit(bus.addr, `ADQ_L_ENABLES)) begin
         nxt_st.en6 = bus.wdata[`ADQ_B_DONE];
      end
      if (bus.wr && hit(bus.addr & `ADQ_BANK_MASK, `ADQ_CORE)) begin
         nxt_st.global_irq_gate   = bus.wdata[`ADQ_B_GIE];
         nxt_st.core6 = bus.wdata[`ADQ_B_DONE];
      end

      // Trigger only starts from acquisition with the converter on
      if (trig_hit && nxt_st.ctrl.on && st_ff.fsm == ST_ACQ) begin
         nxt_st.ctrl.go = 1'b1;
      end

      case (st_ff.fsm)
         ST_ACQ: begin
            if (nxt_st.ctrl.go) begin
               nxt_st.wait_cnt = 3'h0;
               if (nxt_st.ctrl.clk_sel == `ADQ_CS_RC) begin
                  nxt_st.fsm = ST_RCWAIT;
               end else begin
                  nxt_st.fsm = ST_CONV;
                  sar_start  = 1'b1;
               end
            end
         end
         ST_RCWAIT: begin
            if (!nxt_st.ctrl.on) begin
               nxt_st.fsm = ST_ACQ;
            end else if (!nxt_st.ctrl.go) begin
               nxt_st.fsm      = ST_ABWAIT;
               nxt_st.wait_cnt = 3'h0;
            end else if (st_ff.wait_cnt == INSTR_LAST) begin
               nxt_st.fsm = ST_CONV;
               sar_start  = 1'b1;
            end else begin
               nxt_st.wait_cnt = st_ff.wait_cnt + 3'h1;
            end
         end
         ST_CONV: begin
            if (!nxt_st.ctrl.on) begin
               sar_abort      = 1'b1;
               nxt_st.ctrl.go = 1'b0;
               nxt_st.fsm     = ST_ACQ;
            end else if (!nxt_st.ctrl.go) begin
               sar_abort       = 1'b1;
               // Restart the divider so the settle wait spans whole clocks
               nxt_st.div_cnt  = 5'h00;
               nxt_st.fsm      = ST_ABWAIT;
               nxt_st.wait_cnt = 3'h0;
            end else if (sleep && !rc_mode) begin
               // Only the RC clock keeps converting through sleep
               sar_abort      = 1'b1;
               nxt_st.ctrl.go = 1'b0;
               nxt_st.fsm     = ST_ACQ;
            end else if (sar_done) begin
               nxt_st.ctrl.go = 1'b0;
               nxt_st.result  = sar_result;
               flag_set       = 1'b1;
               nxt_st.fsm     = ST_ACQ;
            end
         end
         ST_ABWAIT: begin
            // Start requests are dropped until the settle wait ends
            nxt_st.ctrl.go = 1'b0;
            if (st_ff.wait_cnt == `ADQ_ABORT_TADS) begin
               nxt_st.fsm = ST_ACQ;
            end else if (tad_tick) begin
               nxt_st.wait_cnt = st_ff.wait_cnt + 3'h1;
            end
         end
         default: begin
            nxt_st.fsm = ST_ACQ;
         end
      endcase

      // Completion wins over a clear in the same cycle
      nxt_st.flag = (st_ff.flag & ~flag_clr) | flag_set;

      // Read data stand in the cycle after the strobe only
      nxt_st.rdata = 8'h00;
      if (bus.rd) begin
         if (hit(bus.addr, CTRL_OFF)) begin
            nxt_st.rdata = SMALL
               ? {st_ff.ctrl.clk_sel, 1'b0, st_ff.ctrl.chan[1:0], st_ff.ctrl.go,
                  st_ff.flag, st_ff.ctrl.on}
               : {st_ff.ctrl.clk_sel, st_ff.ctrl.chan, st_ff.ctrl.go,
                  1'b0, st_ff.ctrl.on};
         end else if (hit(bus.addr, RESULT_OFF)) begin
            nxt_st.rdata = st_ff.result;
         end else if (hit(bus.addr, CFG_OFF)) begin
            nxt_st.rdata = {5'h00, st_ff.cfg};
         end else if (!SMALL && hit(bus.addr, `ADQ_L_FLAGS)) begin
            nxt_st.rdata = {1'b0, st_ff.flag, 6'h00};
         end else if (!SMALL && hit(bus.addr, `ADQ_L_ENABLES)) begin
            nxt_st.rdata = {1'b0, st_ff.en6, 6'h00};
         end else if (hit(bus.addr & `ADQ_BANK_MASK, `ADQ_CORE)) begin
            nxt_st.rdata = {st_ff.global_irq_gate, st_ff.core6, 6'h00};
         end
      end
   end

   // Any reset returns everything to zero and kills a conversion
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rdata        = st_ff.rdata;
   assign timer_clear  = st_ff.tclr;
   assign irq          = st_ff.global_irq_gate & st_ff.core6 & st_ff.flag & (SMALL | st_ff.en6);
   assign ana          = '{chan:     st_ff.ctrl.chan,
                           dac:      sar_trial,
                           sample:   st_ff.ctrl.on & (st_ff.fsm == ST_ACQ),
                           powered:  st_ff.ctrl.on,
                           port_cfg: st_ff.cfg};

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_trig_start;
      trig_hit && st_ff.ctrl.on && st_ff.fsm == ST_ACQ && !wr_ctrl
         |=> st_ff.ctrl.go && st_ff.fsm != ST_ACQ;
   endproperty
   a_trig_start: assert property (p_trig_start)
      else $error("trigger did not start a conversion");

   property p_timer_clear;
      trig_hit |=> timer_clear ##0 (trig_hit or ##1 !timer_clear) ;
   endproperty
   a_timer_clear: assert property (p_timer_clear)
      else $error("timer clear not pulsed after trigger");

   property p_off_ignore;
      trig_hit && !st_ff.ctrl.on && !wr_ctrl |=> !st_ff.ctrl.go ##0 timer_clear;
   endproperty
   a_off_ignore: assert property (p_off_ignore)
      else $error("trigger acted while converter off");

   property p_ctrl_bit1;
      bus.rd && hit(bus.addr, CTRL_OFF) && !SMALL |=> rdata[1] == 1'b0;
   endproperty
   a_ctrl_bit1: assert property (p_ctrl_bit1)
      else $error("unimplemented control bit read as one");

   property p_cfg_read;
      bus.rd && hit(bus.addr, CFG_OFF) |=> rdata == {5'h00, $past(st_ff.cfg)};
   endproperty
   a_cfg_read: assert property (p_cfg_read)
      else $error("port configuration read wrong");

   property p_done;
      st_ff.fsm == ST_CONV && sar_done && st_ff.ctrl.on && !wr_ctrl
         && !(sleep && !rc_mode)
         |=> !st_ff.ctrl.go && st_ff.flag && st_ff.result == $past(sar_result);
   endproperty
   a_done: assert property (p_done)
      else $error("completion did not update start, result and flag");

   property p_abort_keep;
      st_ff.fsm == ST_CONV && wr_ctrl && bus.wdata[`ADQ_B_ON] && !bus.wdata[`ADQ_B_GO]
         |=> st_ff.fsm == ST_ABWAIT && $stable(st_ff.result) && !sar_busy;
   endproperty
   a_abort_keep: assert property (p_abort_keep)
      else $error("abort changed result or skipped wait");

   property p_rc_wait;
      (st_ff.fsm == ST_RCWAIT && $past(st_ff.fsm) == ST_ACQ && !wr_ctrl)
         ##1 (!wr_ctrl)[*3] |=> st_ff.fsm == ST_CONV && sar_busy;
   endproperty
   a_rc_wait: assert property (p_rc_wait)
      else $error("RC start wait not one instruction");

   property p_irq;
      $rose(st_ff.flag) && st_ff.global_irq_gate && st_ff.core6 && (SMALL || st_ff.en6) |-> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("enabled done flag raised no interrupt");

   c_trig:  cover property (trig_hit && st_ff.ctrl.on ##1 st_ff.fsm == ST_CONV);
   c_done:  cover property (st_ff.fsm == ST_CONV && sar_done);
   c_abort: cover property (st_ff.fsm == ST_ABWAIT ##1 st_ff.fsm == ST_ACQ);
   c_rc:    cover property (st_ff.fsm == ST_RCWAIT ##4 st_ff.fsm == ST_CONV);

endmodule

//--- adq_params.svh
`ifndef ADQ_PARAMS_SVH
`define ADQ_PARAMS_SVH

// ----------------------------------------
// Register offsets, larger variants
// ----------------------------------------
`define ADQ_L_FLAGS    8'h0C
`define ADQ_L_RESULT   8'h1E
`define ADQ_L_CTRL     8'h1F
`define ADQ_L_ENABLES  8'h8C
`define ADQ_L_CFG      8'h9F
// ----------------------------------------
// Register offsets, smallest variants
// ----------------------------------------
`define ADQ_S_CTRL     8'h08
`define ADQ_S_CFG      8'h88
`define ADQ_S_RESULT   8'h89
// ----------------------------------------
// Core interrupt control, both banks
// ----------------------------------------
`define ADQ_CORE       8'h0B
`define ADQ_BANK_MASK  8'h7F
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADQ_B_ON       0
`define ADQ_B_FLAG_S   1
`define ADQ_B_GO       2
`define ADQ_B_DONE     6
`define ADQ_B_GIE      7
// ----------------------------------------
// Codes and timing
// ----------------------------------------
`define ADQ_SPECIAL_TRIG 4'hB
`define ADQ_CS_RC      2'h3
`define ADQ_DIV_2T     5'h01
`define ADQ_DIV_8T     5'h07
`define ADQ_DIV_32T    5'h1F
`define ADQ_TOSC_NS    10
`define ADQ_INSTR_NS   40
`define ADQ_INSTR_CYC  ((`ADQ_INSTR_NS + `ADQ_TOSC_NS - 1) / `ADQ_TOSC_NS)
`define ADQ_ABORT_TADS 3'h2

`endif

//--- adq_pkg.sv
package adq_pkg;

   typedef enum logic [1:0] {ST_ACQ, ST_RCWAIT, ST_CONV, ST_ABWAIT} adq_fsm_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } adq_bus_t;

   typedef struct packed {
      logic [3:0] mode;
      logic       event_p;
   } adq_cmp_t;

   typedef struct packed {
      logic [2:0] chan;
      logic [7:0] dac;
      logic       sample;
      logic       powered;
      logic [2:0] port_cfg;
   } adq_ana_t;

   typedef struct packed {
      logic [1:0] clk_sel;
      logic [2:0] chan;
      logic       go;
      logic       on;
   } adq_ctrl_t;

   typedef struct packed {
      adq_fsm_t   fsm;
      adq_ctrl_t  ctrl;
      logic [2:0] cfg;
      logic [7:0] result;
      logic       flag;
      logic       en6;
      logic       global_irq_gate;
      logic       core6;
      logic [4:0] div_cnt;
      logic [2:0] wait_cnt;
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [1:0] sync3;
      logic [1:0] stable;
      logic       rc_prev;
      logic       tclr;
      logic [7:0] rdata;
   } adq_state_t;

endpackage

//--- adq_sar.sv
`timescale 1ns/100ps

module adq_sar #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             start,
   input  wire logic             abort,
   input  wire logic             tick,
   input  wire logic             comp,
   output logic                  busy,
   output logic                  done,
   output logic [WIDTH-1:0]      trial,
   output logic [WIDTH-1:0]      result
);

   if (WIDTH < 2) begin : g_chk
      $error("adq_sar: WIDTH must be at least 2");
   end

   typedef struct packed {
      logic             busy;
      logic             done;
      logic [WIDTH-1:0] mask;
      logic [WIDTH-1:0] trial;
      logic [WIDTH-1:0] result;
   } sar_st_t;

   sar_st_t st_ff;
   sar_st_t nxt_st;
   logic [WIDTH-1:0] kept;

   // ----------------------------------------
   // Binary search, one bit per conversion clock
   // ----------------------------------------
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.done = 1'b0;
      // Comparator high means input at or above trial code
      kept = comp ? st_ff.trial : (st_ff.trial & ~st_ff.mask);
      if (abort) begin
         nxt_st.busy = 1'b0;
      end else if (start) begin
         nxt_st.busy  = 1'b1;
         nxt_st.mask  = {1'b1, {(WIDTH-1){1'b0}}};
         nxt_st.trial = {1'b1, {(WIDTH-1){1'b0}}};
      end else if (st_ff.busy && tick) begin
         if (st_ff.mask[0]) begin
            nxt_st.busy   = 1'b0;
            nxt_st.done   = 1'b1;
            nxt_st.result = kept;
            nxt_st.trial  = kept;
         end else begin
            nxt_st.mask  = st_ff.mask >> 1;
            nxt_st.trial = kept | (st_ff.mask >> 1);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign busy   = st_ff.busy;
   assign done   = st_ff.done;
   assign trial  = st_ff.trial;
   assign result = st_ff.result;

endmodule

//--- adq_far_model.sv
`timescale 1ns/100ps

module adq_far_model
   import adq_pkg::*;
(
   input  wire adq_ana_t    ana,
   input  wire logic [63:0] vin,
   output logic             comp_pin,
   output logic             rc_clk_pin
);
   // ------
   // RC oscillator and comparator
   // ------
   // Free running, phase unrelated to the core clock
   initial begin
      rc_clk_pin = 1'b0;
      forever #83 rc_clk_pin = ~rc_clk_pin;
   end

   // Ideal comparator, one step is the reference over 256
   always_comb begin
      comp_pin = (vin[ana.chan*8 +: 8] >= ana.dac);
   end
endmodule

//--- adc_sequencer_with_event_trigger_tb_top.sv
`timescale 1ns/100ps
`include "adq_params.svh"

module adc_sequencer_with_event_trigger_tb_top
   import adq_pkg::*;
;
   logic        clk;
   logic        rst_n;
   adq_bus_t    bus;
   logic [7:0]  rdata;
   adq_cmp_t    cmp1;
   adq_cmp_t    cmp2;
   logic        comp_pin;
   logic        rc_clk_pin;
   logic        sleep;
   logic        irq;
   logic        timer_clear;
   adq_ana_t    ana;
   logic [63:0] vin;
   int          n_fail;
   int          samples_checked;

   adq_top #(.SMALL(1'b0), .TRIG_FIRST(1'b0)) dut_u (
      .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .cmp1(cmp1), .cmp2(cmp2),
      .comp_pin(comp_pin), .rc_clk_pin(rc_clk_pin), .sleep(sleep), .irq(irq),
      .timer_clear(timer_clear), .ana(ana)
   );

   adq_far_model far_u (.ana(ana), .vin(vin), .comp_pin(comp_pin), .rc_clk_pin(rc_clk_pin));

   // ------
   // Bus and check tasks
   // ------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic settle();
      @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [7:0] v;
      rd(a, v);
      chk(what, v, exp);
   endtask

   // One-cycle event from the chosen compare unit
   task automatic trig(input logic first, input logic [3:0] mode);
      @(posedge clk);
      if (first) cmp1 <= '{mode: mode, event_p: 1'b1};
      else cmp2 <= '{mode: mode, event_p: 1'b1};
      @(posedge clk);
      cmp1.event_p <= 1'b0;
      cmp2.event_p <= 1'b0;
      #1;
   endtask

   task automatic wait_done();
      logic [7:0] v;
      for (int i = 0; i < 400; i++) begin
         rd(`ADQ_L_CTRL, v);
         if (v[`ADQ_B_GO] === 1'b0) return;
      end
      chk("conversion end", 8'h01, 8'h00);
      close_out();
   endtask

   task automatic convert(input logic [1:0] cs, input logic [2:0] ch, input logic [7:0] v,
                          input logic use_trig);
      vin[ch*8 +: 8] = v;
      wr(`ADQ_L_CTRL, {cs, ch, 3'b001});
      repeat (20) @(posedge clk);
      if (use_trig) begin
         trig(1'b0, `ADQ_SPECIAL_TRIG);
         chk("timer_clear", {7'h00, timer_clear}, 8'h01);
         rchk(`ADQ_L_CTRL, {cs, ch, 3'b101}, "go after trigger");
      end else begin
         wr(`ADQ_L_CTRL, {cs, ch, 3'b101});
      end
      // RC clock keeps converting while the core sleeps
      @(posedge clk) sleep <= (cs == `ADQ_CS_RC);
      wait_done();
      @(posedge clk) sleep <= 1'b0;
      rchk(`ADQ_L_RESULT, v, "result");
      rchk(`ADQ_L_FLAGS, 8'h40, "done flag");
   endtask

   // ------
   // Scenarios
   // ------
   task automatic t_reset();
      rchk(`ADQ_L_CTRL, 8'h00, "control reset");
      rchk(`ADQ_L_CFG, 8'h00, "config reset");
      rchk(`ADQ_L_FLAGS, 8'h00, "flags reset");
      rchk(`ADQ_L_ENABLES, 8'h00, "enables reset");
      rchk(8'h50, 8'h00, "unmapped read");
      chk("irq", {7'h00, irq}, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_regs();
      wr(`ADQ_L_CTRL, 8'hFA);
      rchk(`ADQ_L_CTRL, 8'hF8, "control fields");
      chk("ana chan", {5'h00, ana.chan}, 8'h07);
      settle();
      chk("rdata after read", rdata, 8'h00);
      wr(`ADQ_L_CFG, 8'hFF);
      rchk(`ADQ_L_CFG, 8'h07, "config field");
      chk("ana port_cfg", {5'h00, ana.port_cfg}, 8'h07);
      wr(`ADQ_L_ENABLES, 8'h7F);
      rchk(`ADQ_L_ENABLES, 8'h40, "enables field");
      wr(`ADQ_L_CTRL, 8'h00);
      wr(`ADQ_L_CFG, 8'h00);
      wr(`ADQ_L_ENABLES, 8'h00);
      $display("test registers done");
   endtask

   task automatic t_trig();
      trig(1'b0, `ADQ_SPECIAL_TRIG);
      chk("timer_clear while off", {7'h00, timer_clear}, 8'h01);
      settle();
      chk("timer_clear length", {7'h00, timer_clear}, 8'h00);
      rchk(`ADQ_L_CTRL, 8'h00, "no start while off");
      wr(`ADQ_L_CTRL, 8'h81);
      trig(1'b0, 4'hA);
      chk("timer_clear other mode", {7'h00, timer_clear}, 8'h00);
      trig(1'b1, `ADQ_SPECIAL_TRIG);
      chk("timer_clear unit one", {7'h00, timer_clear}, 8'h00);
      rchk(`ADQ_L_CTRL, 8'h81, "no start");
      $display("test trigger done");
   endtask

   task automatic t_conv();
      convert(2'h2, 3'h5, 8'h01, 1'b1);
      wr(`ADQ_L_FLAGS, 8'h40);
      convert(2'h1, 3'h3, 8'hFF, 1'b0);
      wr(`ADQ_L_FLAGS, 8'h40);
      convert(`ADQ_CS_RC, 3'h1, 8'h5A, 1'b0);
      wr(`ADQ_L_FLAGS, 8'h40);
      convert(2'h2, 3'h2, 8'h00, 1'b0);
      wr(`ADQ_L_FLAGS, 8'h40);
      $display("test conversions done");
   endtask

   task automatic t_irq();
      wr(`ADQ_L_ENABLES, 8'h40);
      wr(`ADQ_CORE, 8'hC0);
      convert(2'h2, 3'h0, 8'hA5, 1'b1);
      chk("irq raised", {7'h00, irq}, 8'h01);
      wr(`ADQ_L_ENABLES, 8'h00);
      settle();
      chk("irq masked", {7'h00, irq}, 8'h00);
      wr(`ADQ_L_ENABLES, 8'h40);
      settle();
      chk("irq unmasked", {7'h00, irq}, 8'h01);
      wr(`ADQ_L_FLAGS, 8'h40);
      settle();
      chk("irq cleared", {7'h00, irq}, 8'h00);
      rchk(`ADQ_L_FLAGS, 8'h00, "flag cleared");
      wr(`ADQ_CORE, 8'h00);
      wr(`ADQ_L_ENABLES, 8'h00);
      $display("test interrupt done");
   endtask

   task automatic t_abort();
      convert(2'h2, 3'h0, 8'h3C, 1'b0);
      wr(`ADQ_L_FLAGS, 8'h40);
      vin[7:0] = 8'hC3;
      wr(`ADQ_L_CTRL, 8'h85);
      repeat (40) @(posedge clk);
      wr(`ADQ_L_CTRL, 8'h81);
      repeat (60) @(posedge clk);
      #1;
      chk("sample in abort wait", {7'h00, ana.sample}, 8'h00);
      repeat (20) @(posedge clk);
      #1;
      chk("sample after wait", {7'h00, ana.sample}, 8'h01);
      rchk(`ADQ_L_RESULT, 8'h3C, "result kept");
      rchk(`ADQ_L_FLAGS, 8'h00, "no flag on abort");
      rchk(`ADQ_L_CTRL, 8'h81, "control after abort");
      // Sleep with a core-derived clock kills the conversion, on bit kept
      wr(`ADQ_L_CTRL, 8'h85);
      repeat (40) @(posedge clk);
      @(posedge clk) sleep <= 1'b1;
      @(posedge clk) sleep <= 1'b0;
      rchk(`ADQ_L_CTRL, 8'h81, "control after sleep");
      rchk(`ADQ_L_RESULT, 8'h3C, "result kept in sleep");
      $display("test abort done");
   endtask

   task automatic t_reset_mid();
      wr(`ADQ_L_CTRL, 8'h85);
      repeat (40) @(posedge clk);
      @(posedge clk) rst_n <= 1'b0;
      settle();
      chk("powered in reset", {7'h00, ana.powered}, 8'h00);
      chk("dac in reset", ana.dac, 8'h00);
      @(posedge clk) rst_n <= 1'b1;
      rchk(`ADQ_L_CTRL, 8'h00, "control after reset");
      rchk(`ADQ_L_FLAGS, 8'h00, "flags after reset");
      $display("test reset mid-run done");
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      bus = '0;
      cmp1 = '0;
      cmp2 = '0;
      sleep = 1'b0;
      vin = '0;
      rst_n = 1'b0;
      n_fail = 0;
      samples_checked = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_trig();
      t_conv();
      t_irq();
      t_abort();
      t_reset_mid();
      close_out();
   end
endmodule
